// >>> core/sfe_ctrl.sv
// Fallback generator, learning and audio embed control with APB registers
//
// Contract
// - Valid selected input passes through immediately
// - Input loss gives grey for seven seconds
// - Then stored 720 or 1080 image
// - Changeover may drop lock, under two seconds
// - Full-time mode: image always, input timing only
// - Input-present follows validity, even full-time
// - Passed input keeps its format and rate
// - Generator uses stored format and rate
// - Auto mode learns after five seconds valid
// - Only supported format/rate pairs are learned
// - Locked mode never changes stored pair
// - Overlay enabled draws fixed moving red box
// - Box only on generated images
// - Eight channels, four pairs, nine embed settings
// - Channel present needs embedding and level
// - Embedding on passed and generated video
// - Passing replaces selected groups, keeps others
// - Generated video: packets only configured groups
// - Control input low disables embedding
// - Status output polarity is configurable
// - Setting selects coaxial or optical input
// - Control input ignored when function disabled
//
// Implementation choices: the placing of the registers and register access over APB.
`include "sfe_map.svh"
module sfe_ctrl
  import sfe_pkg::*;
#(
  parameter logic [31:0] GREY_CYC   = `SFE_GREY_CYC,
  parameter logic [31:0] LEARN_CYC  = `SFE_LEARN_CYC,
  parameter logic [31:0] SWITCH_CYC = `SFE_SWITCH_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receivers, same clock
  input  wire logic        coax_valid,
  input  wire logic [1:0]  coax_fmt,
  input  wire logic [1:0]  coax_rate,
  input  wire logic        opt_valid,
  input  wire logic [1:0]  opt_fmt,
  input  wire logic [1:0]  opt_rate,
  // Generator timing, same clock
  input  wire logic        gen_frame,
  // Audio level above threshold per channel, same clock
  input  wire logic [7:0]  ch_level_ok,
  // Pins
  input  wire logic        embed_disable_input,
  input  wire logic        sdi_ref_clk,
  // Video path control
  output sfe_src_e         out_src,
  output logic             out_blank,
  output logic [1:0]       out_fmt,
  output logic [1:0]       out_rate,
  output logic             img_1080,
  output logic             ref_tick,
  // Overlay
  output logic             box_on,
  output logic [10:0]      box_x,
  output logic [10:0]      box_y,
  output logic [10:0]      box_size,
  output logic [23:0]      box_color,
  // Nonvolatile store
  output logic             nv_write,
  output logic [1:0]       nv_fmt,
  output logic [1:0]       nv_rate,
  // Audio embedder
  output logic [3:0]       grp_embed,
  output logic [3:0]       grp_keep,
  output logic [3:0]       pair_embed,
  output logic [7:0]       ch_present,
  // Indicators
  output logic             input_present,
  output logic             input_valid_output
);

  // ***********************************************************
  // Input selection and synchronisers
  // ***********************************************************
  logic [31:0] ctrl;            // Control register
  logic        gpi_s1, gpi_s2;  // Control input sync
  logic        ref_s1, ref_s2;  // Reference clock sync
  logic        ref_d;           // Last sampled reference level
  logic        sel_valid;       // Selected input valid
  logic [1:0]  sel_fmt;         // Selected input format
  logic [1:0]  sel_rate;        // Selected input rate

  assign sel_valid = ctrl[`SFE_B_INSEL] ? opt_valid : coax_valid;
  assign sel_fmt   = ctrl[`SFE_B_INSEL] ? opt_fmt   : coax_fmt;
  assign sel_rate  = ctrl[`SFE_B_INSEL] ? opt_rate  : coax_rate;

  // Two-stage syncs for asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpi_s1 <= 1'b1;
      gpi_s2 <= 1'b1;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_d  <= 1'b0;
    end else begin
      gpi_s1 <= embed_disable_input;
      gpi_s2 <= gpi_s1;
      ref_s1 <= sdi_ref_clk;
      ref_s2 <= ref_s1;
      ref_d  <= ref_s2;
    end
  end

  // Reference edges time the generator while input valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= sel_valid & ref_s2 & ~ref_d;
    end
  end

  // ***********************************************************
  // Source state machine
  // ***********************************************************
  sfe_src_e    src, next_src;   // Current and next source
  logic [31:0] grey_cnt;        // Grey interval counter
  logic [31:0] sw_cnt;          // Changeover blank counter
  logic        fulltime;        // Full-time generation

  assign fulltime = ctrl[`SFE_B_FULLTIME];

  // Next-source decision
  always_comb begin
    next_src = src;
    case (src)
      SFE_PASS: begin
        if (fulltime) begin
          next_src = SFE_IMAGE;
        end else if (!sel_valid) begin
          next_src = SFE_GREY;
        end
      end
      SFE_GREY: begin
        if (fulltime) begin
          next_src = SFE_IMAGE;
        end else if (sel_valid) begin
          next_src = SFE_PASS;
        end else if (grey_cnt >= GREY_CYC - 32'd1) begin
          next_src = SFE_IMAGE;
        end
      end
      SFE_IMAGE: begin
        if (!fulltime && sel_valid) begin
          next_src = SFE_PASS;
        end
      end
      default: next_src = SFE_GREY;
    endcase
  end

  // Source register; grey is the power-up fallback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src <= SFE_GREY;
    end else begin
      src <= next_src;
    end
  end

  // Grey timer restarts on every entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grey_cnt <= 32'd0;
    end else if (src != SFE_GREY) begin
      grey_cnt <= 32'd0;
    end else begin
      grey_cnt <= grey_cnt + 32'd1;
    end
  end

  // Blank output briefly across a changeover into or out of pass; the
  // generator needs time to relock and we do not try to hide it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt <= 32'd0;
    end else if (next_src != src && (next_src == SFE_PASS || src == SFE_PASS)) begin
      sw_cnt <= SWITCH_CYC;
    end else if (sw_cnt != 32'd0) begin
      sw_cnt <= sw_cnt - 32'd1;
    end
  end

  // ***********************************************************
  // Format and rate: stored pair and learning
  // ***********************************************************
  logic [1:0]  st_fmt;          // Stored format
  logic [1:0]  st_rate;         // Stored rate
  logic [31:0] learn_cnt;       // Continuous-valid counter
  logic        learned;         // Learning done this stretch
  logic        pair_ok;         // Pair is supported
  logic        learn_now;       // Store this cycle
  logic [15:0] ok_mask;         // Supported pair table

  assign ok_mask = `SFE_FMT_OK_MASK;
  assign pair_ok = ok_mask[{sel_fmt, sel_rate}];
  // Learn only in auto mode after five seconds
  assign learn_now = sel_valid && !ctrl[`SFE_B_LOCKED] && !learned
                     && pair_ok && learn_cnt >= LEARN_CYC - 32'd1;

  // Valid-stretch counter; saturates at LEARN_CYC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      learn_cnt <= 32'd0;
      learned   <= 1'b0;
    end else if (!sel_valid) begin
      learn_cnt <= 32'd0;
      learned   <= 1'b0;
    end else begin
      if (learn_cnt < LEARN_CYC) begin
        learn_cnt <= learn_cnt + 32'd1;
      end
      if (learn_now) begin
        learned <= 1'b1;
      end
    end
  end

  // Stored pair, mirrored to the nonvolatile write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_fmt   <= `SFE_FMT_RST;
      st_rate  <= `SFE_RATE_RST;
      nv_write <= 1'b0;
      nv_fmt   <= `SFE_FMT_RST;
      nv_rate  <= `SFE_RATE_RST;
    end else begin
      nv_write <= learn_now;
      if (learn_now) begin
        st_fmt  <= sel_fmt;
        st_rate <= sel_rate;
        nv_fmt  <= sel_fmt;
        nv_rate <= sel_rate;
      end
    end
  end

  // Video path outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_src   <= SFE_GREY;
      out_blank <= 1'b0;
      out_fmt   <= `SFE_FMT_RST;
      out_rate  <= `SFE_RATE_RST;
      img_1080  <= 1'b1;
    end else begin
      out_src   <= src;
      out_blank <= (sw_cnt != 32'd0);
      // Pass keeps source format; else stored
      out_fmt   <= (src == SFE_PASS) ? sel_fmt : st_fmt;
      out_rate  <= (src == SFE_PASS) ? sel_rate : st_rate;
      img_1080  <= (st_fmt != 2'h0);
    end
  end

  // ***********************************************************
  // Moving overlay box
  // ***********************************************************
  logic [10:0] lim_x, lim_y;    // Right and bottom travel limits
  logic        dir_x, dir_y;    // Travel direction, 1 = forward

  assign lim_x = (st_fmt != 2'h0 ? `SFE_W1080 : `SFE_W720) - `SFE_BOX_SIZE;
  assign lim_y = (st_fmt != 2'h0 ? `SFE_H1080 : `SFE_H720) - `SFE_BOX_SIZE;
  assign box_size  = `SFE_BOX_SIZE;
  assign box_color = `SFE_BOX_COLOR;

  // Box shown and moved only on the stored image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      box_on <= 1'b0;
      box_x  <= 11'h000;
      box_y  <= 11'h000;
      dir_x  <= 1'b1;
      dir_y  <= 1'b1;
    end else begin
      box_on <= ctrl[`SFE_B_OVERLAY] && src == SFE_IMAGE;
      if (gen_frame && src == SFE_IMAGE) begin
        if (dir_x ? box_x >= lim_x - `SFE_BOX_STEP : box_x < `SFE_BOX_STEP) begin
          dir_x <= ~dir_x;
        end else begin
          box_x <= dir_x ? box_x + `SFE_BOX_STEP : box_x - `SFE_BOX_STEP;
        end
        if (dir_y ? box_y >= lim_y - `SFE_BOX_STEP : box_y < `SFE_BOX_STEP) begin
          dir_y <= ~dir_y;
        end else begin
          box_y <= dir_y ? box_y + `SFE_BOX_STEP : box_y - `SFE_BOX_STEP;
        end
      end
    end
  end

  // ***********************************************************
  // Audio embedding
  // ***********************************************************
  logic [3:0] setting;          // Embed setting 0..8
  logic       embed_on;         // Embedder enabled now
  logic [3:0] grp_cfg;          // Groups for the setting
  logic [3:0] pair_cfg;         // Pairs for the setting

  assign setting = ctrl[`SFE_B_EMBED +: 4];
  // Low control input only counts when enabled
  assign embed_on = setting != 4'h0 && setting <= 4'h8
                    && !(ctrl[`SFE_B_GPI_EN] && !gpi_s2);

  // Settings 1-4: pairs 1-2 to one group; 5-8: all pairs
  always_comb begin
    grp_cfg  = 4'h0;
    pair_cfg = 4'h0;
    case (setting)
      4'h1, 4'h2, 4'h3, 4'h4: begin
        grp_cfg  = 4'h1 << (setting - 4'h1);
        pair_cfg = 4'h3;
      end
      4'h5: begin
        grp_cfg  = 4'h3;
        pair_cfg = 4'hF;
      end
      4'h6: begin
        grp_cfg  = 4'h6;
        pair_cfg = 4'hF;
      end
      4'h7: begin
        grp_cfg  = 4'hC;
        pair_cfg = 4'hF;
      end
      4'h8: begin
        grp_cfg  = 4'h9;
        pair_cfg = 4'hF;
      end
      default: begin
        grp_cfg  = 4'h0;
        pair_cfg = 4'h0;
      end
    endcase
  end

  // Embedder controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_embed  <= 4'h0;
      grp_keep   <= 4'h0;
      pair_embed <= 4'h0;
    end else begin
      grp_embed  <= embed_on ? grp_cfg : 4'h0;
      pair_embed <= embed_on ? pair_cfg : 4'h0;
      // Input groups kept only when passing
      grp_keep   <= (src == SFE_PASS) ? ~(embed_on ? grp_cfg : 4'h0) : 4'h0;
    end
  end

  for (genvar ch = 0; ch < 8; ch++) begin : g_chp
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_present[ch] <= 1'b0;
      end else begin
        ch_present[ch] <= embed_on && pair_cfg[ch/2] && ch_level_ok[ch];
      end
    end
  end

  // ***********************************************************
  // Indicators
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_present      <= 1'b0;
      input_valid_output <= 1'b0;
    end else begin
      input_present <= sel_valid;
      case (sfe_gpo_e'(ctrl[`SFE_B_GPO +: 2]))
        SFE_GPO_VALID:    input_valid_output <= sel_valid;
        SFE_GPO_NOTVALID: input_valid_output <= !sel_valid;
        default:          input_valid_output <= 1'b0;
      endcase
    end
  end

  // ***********************************************************
  // APB slave
  // ***********************************************************
  logic acc;                    // Access phase
  logic hit;                    // Mapped offset

  assign acc     = psel && penable;
  assign hit     = paddr == `SFE_OFS_CTRL || paddr == `SFE_OFS_STATUS
                   || paddr == `SFE_OFS_STORED;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  // Only the control word is writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SFE_CTRL_RST;
    end else if (acc && pwrite && paddr == `SFE_OFS_CTRL) begin
      ctrl <= pwdata & `SFE_CTRL_MASK;
    end
  end

  // Read mux, registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SFE_OFS_CTRL:   prdata <= ctrl;
        `SFE_OFS_STATUS: prdata <= {16'h0000, ch_present, 2'h0, learned,
                                    out_blank, src, embed_on, sel_valid};
        `SFE_OFS_STORED: prdata <= {28'h0000000, st_fmt, st_rate};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lost;
    src == SFE_PASS && !fulltime && !sel_valid;
  endsequence
  sequence s_back;
    src == SFE_GREY && !fulltime && sel_valid;
  endsequence

  property p_pass_now;
    !fulltime && sel_valid && src != SFE_PASS |=> src == SFE_PASS;
  endproperty
  a_pass_now: assert property (p_pass_now) else $error("valid input not passed");

  property p_grey_on_loss;
    s_lost |=> src == SFE_GREY ##1 out_src == SFE_GREY;
  endproperty
  a_grey_on_loss: assert property (p_grey_on_loss) else $error("no grey on loss");

  property p_grey_len;
    src == SFE_GREY && grey_cnt == GREY_CYC - 32'd1 && !sel_valid && !fulltime
      |=> src == SFE_IMAGE;
  endproperty
  a_grey_len: assert property (p_grey_len) else $error("grey interval wrong");

  property p_grey_cancel;
    s_back |=> src == SFE_PASS ##1 grey_cnt == 32'd0;
  endproperty
  a_grey_cancel: assert property (p_grey_cancel) else $error("grey not cancelled");

  property p_full;
    fulltime ##1 fulltime |-> src != SFE_PASS;
  endproperty
  a_full: assert property (p_full) else $error("pass in full-time mode");

  property p_locked;
    ctrl[`SFE_B_LOCKED] |=> $stable(st_fmt) && $stable(st_rate) && !nv_write;
  endproperty
  a_locked: assert property (p_locked) else $error("locked pair changed");

  property p_learn_ok;
    nv_write |-> ok_mask[{nv_fmt, nv_rate}] && $past(learn_cnt) >= LEARN_CYC - 32'd1;
  endproperty
  a_learn_ok: assert property (p_learn_ok) else $error("bad learn");

  property p_box;
    box_on |-> $past(src) == SFE_IMAGE;
  endproperty
  a_box: assert property (p_box) else $error("box over input");

  property p_gpi;
    ctrl[`SFE_B_GPI_EN] && !gpi_s2 |=> grp_embed == 4'h0 && ch_present == 8'h00;
  endproperty
  a_gpi: assert property (p_gpi) else $error("embed not disabled");

  property p_gpo;
    ctrl[`SFE_B_GPO +: 2] == 2'h2 |=> input_valid_output == !$past(sel_valid);
  endproperty
  a_gpo: assert property (p_gpo) else $error("status polarity wrong");

endmodule // sfe_ctrl

// >>> inc/sfe_map.svh
// Register map, field positions, reset values and timing counts
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH
// ***********************************************************
// Clock rate and times
// ***********************************************************
`define SFE_CLK_MHZ       100
`define SFE_GREY_MS       7000
`define SFE_LEARN_MS      5000
`define SFE_SWITCH_MS     100
`define SFE_GREY_CYC      (`SFE_GREY_MS * 1000 * `SFE_CLK_MHZ)
`define SFE_LEARN_CYC     (`SFE_LEARN_MS * 1000 * `SFE_CLK_MHZ)
`define SFE_SWITCH_CYC    (`SFE_SWITCH_MS * 1000 * `SFE_CLK_MHZ)
// ***********************************************************
// Register offsets
// ***********************************************************
`define SFE_OFS_CTRL      8'h00
`define SFE_OFS_STATUS    8'h04
`define SFE_OFS_STORED    8'h08
// ***********************************************************
// Control fields
// ***********************************************************
`define SFE_B_INSEL       0
`define SFE_B_FULLTIME    1
`define SFE_B_LOCKED      2
`define SFE_B_OVERLAY     3
`define SFE_B_EMBED       4
`define SFE_B_GPI_EN      8
`define SFE_B_GPO         9
`define SFE_CTRL_RST      32'h0000_0010
`define SFE_CTRL_MASK     32'h0000_07FF
// ***********************************************************
// Stored format/rate, supported pairs, overlay box
// ***********************************************************
`define SFE_FMT_RST       2'h1
`define SFE_RATE_RST      2'h0
`define SFE_FMT_OK_MASK   16'h0777
`define SFE_BOX_SIZE      11'h040
`define SFE_BOX_STEP      11'h002
`define SFE_BOX_COLOR     24'hFF0000
`define SFE_W720          11'h500
`define SFE_H720          11'h2D0
`define SFE_W1080         11'h780
`define SFE_H1080         11'h438
`endif

// >>> inc/sfe_pkg.sv
// Types shared by the fallback/embed control block
package sfe_pkg;
  // Output source
  typedef enum logic [1:0] {
    SFE_PASS,
    SFE_GREY,
    SFE_IMAGE
  } sfe_src_e;
  // INPUT_VALID_OUTPUT behaviour
  typedef enum logic [1:0] {
    SFE_GPO_OFF,
    SFE_GPO_VALID,
    SFE_GPO_NOTVALID,
    SFE_GPO_RSVD
  } sfe_gpo_e;
  typedef logic [1:0] sfe_fmt_t;
endpackage

// >>> verif/sfe_src_model.sv
// Upstream receiver model: validity, format/rate codes, reference clock
module sfe_src_model (
  // Clock and bench control
  input  wire logic       pclk,
  input  wire logic       on,
  input  wire logic       use_opt,
  input  wire logic [1:0] fmt,
  input  wire logic [1:0] rate,
  // Receiver side
  output logic            coax_valid,
  output logic [1:0]      coax_fmt,
  output logic [1:0]      coax_rate,
  output logic            opt_valid,
  output logic [1:0]      opt_fmt,
  output logic [1:0]      opt_rate,
  output logic            sdi_ref_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Known start values
  initial begin
    {coax_valid, coax_fmt, coax_rate} = 5'h00;
    {opt_valid, opt_fmt, opt_rate} = 5'h00;
    sdi_ref_clk = 1'h0;
  end
  // valid with codes
  // Idle codes toggle so a stale code never looks live
  always @(posedge pclk) begin
    coax_valid <= on & ~use_opt;
    opt_valid  <= on & use_opt;
    coax_fmt   <= (on & ~use_opt) ? fmt : ~coax_fmt;
    coax_rate  <= (on & ~use_opt) ? rate : ~coax_rate;
    opt_fmt    <= (on & use_opt) ? fmt : ~opt_fmt;
    opt_rate   <= (on & use_opt) ? rate : ~opt_rate;
  end
  // Reference clock, still while no signal
  always #40 sdi_ref_clk = on ? ~sdi_ref_clk : 1'h0;
endmodule // sfe_src_model

// >>> verif/sfe_ctrl_tb.sv
// Self-checking bench for the fallback/embed control block
module sfe_ctrl_tb import sfe_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // Design and model signals
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, ch_level_ok = 8'h00, ch_present;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed, cycles = 32'h0;
  logic        pready, pslverr, err, coax_valid, opt_valid, sdi_ref_clk, out_blank, img_1080;
  logic        gen_frame = 1'h0, embed_disable_input = 1'h1, on = 1'h0, use_opt = 1'h0;
  logic        ref_tick, box_on, nv_write, input_present, input_valid_output;
  logic [1:0]  coax_fmt, coax_rate, opt_fmt, opt_rate, out_fmt, out_rate, nv_fmt, nv_rate;
  logic [1:0]  fmt = 2'h0, rate = 2'h0;
  logic [3:0]  lrn, grp_embed, grp_keep, pair_embed;
  logic [10:0] box_x, box_y, box_size;
  logic [23:0] box_color;
  sfe_src_e    out_src;
  int          mismatches = 0, n_compared = 0, ticks = 0, t0;

  // Short counts keep the run brief
  sfe_ctrl #(.GREY_CYC(32'd200), .LEARN_CYC(32'd100), .SWITCH_CYC(32'd10)) dut_u (.*);
  sfe_src_model src_u (.*);

  // ***********************************************************
  // Clock, frame pulses, timeout
  // ***********************************************************
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 32'h1;
    gen_frame <= (cycles[3:0] == 4'h0);
    // Reference ticks seen from the design
    if (ref_tick === 1'h1) ticks <= ticks + 1;
    if (cycles == 32'd6000) begin
      mismatches++;
      final_report();
    end
  end

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Groups expected for each embed setting
  function automatic logic [3:0] grp_of(input int s);
    case (s)
      1, 2, 3, 4: return 4'h1 << (s - 1);
      5: return 4'h3;
      6: return 4'h6;
      7: return 4'hC;
      8: return 4'h9;
      default: return 4'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Settle point: half a cycle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // One APB transfer; release happens at the answering edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  initial begin
    seed = 32'h2825;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h10);
    apb(1'h0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, 8'h08, 32'hF);
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h4);
    chk(out_src, SFE_GREY);
    $display("test registers done");
    apb(1'h1, 8'h00, 32'h18);
    cyc(220);
    chk(out_src, SFE_IMAGE);
    chk({img_1080, out_fmt}, 3'h5);
    chk({box_on, box_color}, 25'h1FF0000);
    // Random supported pair passes and is learned
    seed = lfsr(lfsr(seed));
    @(posedge pclk);
    fmt <= 2'(seed % 3);
    rate <= 2'((seed >> 8) % 3);
    on <= 1'h1;
    cyc(5);
    chk(out_src, SFE_PASS);
    chk({out_fmt, out_rate}, {fmt, rate});
    chk({box_on, input_present, out_blank}, 3'h3);
    cyc(120);
    lrn = {fmt, rate};
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, lrn);
    // Loss, return in grey, loss again
    @(posedge pclk);
    on <= 1'h0;
    cyc(5);
    chk(out_src, SFE_GREY);
    @(posedge pclk);
    on <= 1'h1;
    cyc(5);
    chk(out_src, SFE_PASS);
    @(posedge pclk);
    on <= 1'h0;
    cyc(150);
    chk(out_src, SFE_GREY);
    cyc(60);
    chk({out_src, img_1080}, {SFE_IMAGE, fmt != 2'h0});
    $display("test fallback done");
    // Unsupported pair, then locked mode: store unchanged
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, 8'h00, i ? 32'h14 : 32'h10);
      @(posedge pclk);
      fmt <= (lrn[3:2] == 2'h0) ? 2'h1 : 2'h0;
      rate <= i ? 2'h0 : 2'h3;
      on <= 1'h1;
      cyc(130);
      @(posedge pclk);
      on <= 1'h0;
      apb(1'h0, 8'h08, 32'h0);
      chk(rd, lrn);
    end
    // Full-time: never pass, presence still shown
    apb(1'h1, 8'h00, 32'h12);
    @(posedge pclk);
    on <= 1'h1;
    cyc(4);
    t0 = ticks;
    for (int k = 0; k < 4; k++) begin
      cyc(8);
      chk({out_src == SFE_PASS, input_present}, 2'h1);
    end
    chk(ticks > t0, 1'h1);
    // Optical selected while only coax is live
    apb(1'h1, 8'h00, 32'h1);
    cyc(5);
    chk(input_present, 1'h0);
    @(posedge pclk);
    use_opt <= 1'h1;
    cyc(5);
    chk(input_present, 1'h1);
    $display("test modes done");
    // Every embed setting, with control input both ways
    for (int s = 0; s < 9; s++) begin
      seed = lfsr(seed);
      apb(1'h1, 8'h00, 32'h101 | (s << 4));
      @(posedge pclk);
      ch_level_ok <= seed[7:0];
      embed_disable_input <= 1'h1;
      cyc(5);
      chk(grp_embed, grp_of(s));
      chk(pair_embed, s > 4 ? 4'hF : s > 0 ? 4'h3 : 4'h0);
      chk(ch_present, seed[7:0] & (s > 4 ? 8'hFF : s > 0 ? 8'h0F : 8'h00));
      @(posedge pclk);
      embed_disable_input <= 1'h0;
      cyc(5);
      chk(grp_embed, 4'h0);
    end
    apb(1'h1, 8'h00, 32'h31);
    cyc(5);
    chk({grp_embed, grp_keep}, 8'h4B);
    $display("test embed done");
    // Status output polarity, grey video keeps no input groups
    for (int m = 1; m < 3; m++) begin
      for (int v = 0; v < 2; v++) begin
        apb(1'h1, 8'h00, 32'h31 | (m << 9));
        @(posedge pclk);
        on <= v[0];
        cyc(8);
        chk(input_valid_output, (m == 1) ~^ v[0] ? 1'h1 : 1'h0);
        if (v == 0) chk({grp_embed, grp_keep}, 8'h40);
      end
    end
    $display("test status done");
    final_report();
  end
endmodule // sfe_ctrl_tb
